// file: sli_pkg.sv
// shared constants for the scheme logic signal interface
package sli_pkg;

  // ==========================================================
  // clock and scan timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int SCAN_PERIOD_NS = 100;
  localparam int SCAN_DIV = (SCAN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCAN_CNT_W = 8;

  // ==========================================================
  // internal signal vector layout
  localparam int SIG_W = 704;
  localparam int VEC_WORDS = SIG_W / 32;
  localparam int IDX_CONTACT_BASE = 0;
  localparam int IDX_OPTO_BASE = 64;
  localparam int IDX_RED_LED_BASE = 96;
  localparam int IDX_EMERG_START = 108;
  localparam int IDX_MOTOR_START_OK = 298;
  localparam int IDX_FAULT_TRIG = 468;
  localparam int IDX_VOUT_BASE = 512;
  localparam int IDX_VIN_BASE = 544;
  localparam int IDX_CTRL_BASE = 608;
  localparam int IDX_TRI_LED_BASE = 646;
  localparam int IDX_FKEY_BASE = 676;

  // ==========================================================
  // source counts, counter and selector widths
  localparam int N_CONTACT = 16;
  localparam int N_OPTO = 16;
  localparam int N_LED = 8;
  localparam int N_VIO = 32;
  localparam int N_CTRL = 32;
  localparam int N_FKEY = 10;
  localparam int N_PIN = N_OPTO + N_FKEY;
  localparam int CNT_W = 16;
  localparam int SEL_W = 10;

  // ==========================================================
  // register map, byte offsets
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_CTRL_OP = 12'h000;
  localparam logic [11:0] OFF_CTRL_MODE = 12'h004;
  localparam logic [11:0] OFF_CTRL_STATE = 12'h008;
  localparam logic [11:0] OFF_FKEY_MODE = 12'h00c;
  localparam logic [11:0] OFF_FKEY_STATE = 12'h010;
  localparam logic [11:0] OFF_CMD = 12'h014;
  localparam logic [11:0] OFF_VOUT = 12'h018;
  localparam logic [11:0] OFF_LED_DRV = 12'h01c;
  localparam logic [11:0] OFF_LED_LATCH = 12'h020;
  localparam logic [11:0] OFF_LED_CLR = 12'h024;
  localparam logic [11:0] OFF_LED_STATE = 12'h028;
  localparam logic [11:0] OFF_CNT_SEL = 12'h02c;
  localparam logic [11:0] OFF_CNT_THR = 12'h030;
  localparam logic [11:0] OFF_CNT_CLR = 12'h034;
  localparam logic [11:0] OFF_CNT_STATUS = 12'h038;
  localparam logic [11:0] OFF_VEC_SEL = 12'h03c;
  localparam logic [11:0] OFF_VEC_DATA = 12'h040;
  localparam logic [11:0] OFF_VI_MODE = 12'h044;
  localparam logic [11:0] OFF_VI_MASK_BASE = 12'h100;

  // ==========================================================
  // fields and values
  localparam int CMD_EMERG_BIT = 0;
  localparam int CMD_FAULT_BIT = 1;
  localparam int LED_GRN_LSB = 8;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : sli_pkg

// file: sli_event_counter.sv
// edge counter with threshold compare, stepped by the scan tick
`timescale 1ns/1ps
module sli_event_counter (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // control
  input wire logic tick_in,
  input wire logic clr_in,
  input wire logic sig_in,
  input wire logic [sli_pkg::CNT_W-1:0] thr_in,
  // result
  output logic [sli_pkg::CNT_W-1:0] count_out,
  output logic hit_out
);

  logic prev_q;
  logic [sli_pkg::CNT_W-1:0] count_q;
  logic [sli_pkg::CNT_W-1:0] count_d;
  logic hit_q;
  wire rise = tick_in & sig_in & ~prev_q;
  wire sat = &count_q;

  // ==========================================================
  // counting
  assign count_d = clr_in ? '0 : ((rise & ~sat) ? count_q + 1'b1 : count_q);

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      prev_q <= 1'b0;
      count_q <= '0;
      hit_q <= 1'b0;
    end
    else
    begin
      if (tick_in)
      begin
        prev_q <= sig_in;
      end
      count_q <= count_d;
      hit_q <= count_d > thr_in;
    end
  end

  assign count_out = count_q;
  assign hit_out = hit_q;

  // ==========================================================
  // checks
  property p_cnt_thr;
    @(posedge clk_in) disable iff (!rst_n_in)
    hit_q |-> (count_q > $past(thr_in));
  endproperty
  a_cnt_thr: assert property (p_cnt_thr) else $error("counter output high at or below threshold");

  property p_cnt_step;
    @(posedge clk_in) disable iff (!rst_n_in)
    (rise && !clr_in && !sat) |=> (count_q == $past(count_q) + 1'b1);
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("counter missed a rising edge");

  c_cnt_hit: cover property (@(posedge clk_in) disable iff (!rst_n_in) $rose(hit_q));

endmodule : sli_event_counter

// file: sli_signal_if.sv
// scheme logic signal vector with its sources, drives and register slave
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module sli_signal_if (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  // pins from outside
  input wire logic [sli_pkg::N_OPTO-1:0] OPTO_IN,
  input wire logic [sli_pkg::N_FKEY-1:0] FKEY_IN,
  // same-clock sources
  input wire logic [sli_pkg::N_CONTACT-1:0] CONTACT_IN,
  input wire logic MOTOR_START_OK_IN,
  input wire logic [sli_pkg::N_VIO-1:0] VI_PAIR_IN,
  // protection, network and led drives
  output logic EMERG_START_OUT,
  output logic FAULT_TRIG_OUT,
  output logic [sli_pkg::N_VIO-1:0] VIRT_OUT_OUT,
  output logic [sli_pkg::N_LED-1:0] LED_RED_OUT,
  output logic [sli_pkg::N_LED-1:0] LED_GRN_OUT,
  // axi4-lite write
  input wire logic [sli_pkg::ADDR_W-1:0] AXI_AWADDR_IN,
  input wire logic AXI_AWVALID_IN,
  output logic AXI_AWREADY_OUT,
  input wire logic [31:0] AXI_WDATA_IN,
  input wire logic [3:0] AXI_WSTRB_IN,
  input wire logic AXI_WVALID_IN,
  output logic AXI_WREADY_OUT,
  output logic [1:0] AXI_BRESP_OUT,
  output logic AXI_BVALID_OUT,
  input wire logic AXI_BREADY_IN,
  // axi4-lite read
  input wire logic [sli_pkg::ADDR_W-1:0] AXI_ARADDR_IN,
  input wire logic AXI_ARVALID_IN,
  output logic AXI_ARREADY_OUT,
  output logic [31:0] AXI_RDATA_OUT,
  output logic [1:0] AXI_RRESP_OUT,
  output logic AXI_RVALID_OUT,
  input wire logic AXI_RREADY_IN
);

  // ==========================================================
  // scan divider
  logic [sli_pkg::SCAN_CNT_W-1:0] div_q;
  logic scan_tick_q;
  wire div_end = div_q == sli_pkg::SCAN_CNT_W'(sli_pkg::SCAN_DIV - 1);

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      div_q <= '0;
      scan_tick_q <= 1'b0;
    end
    else
    begin
      div_q <= div_end ? '0 : div_q + 1'b1;
      scan_tick_q <= div_end;
    end
  end

  // ==========================================================
  // pin synchronisers, change taken when stages two and three agree
  logic [sli_pkg::N_PIN-1:0] s1_q, s2_q, s3_q, pin_q;
  wire [sli_pkg::N_PIN-1:0] pin_d = (s2_q & s3_q) | (pin_q & (s2_q | s3_q));
  wire [sli_pkg::N_OPTO-1:0] opto_s = pin_q[sli_pkg::N_OPTO-1:0];
  wire [sli_pkg::N_FKEY-1:0] fkey_s = pin_q[sli_pkg::N_PIN-1:sli_pkg::N_OPTO];

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      pin_q <= '0;
    end
    else
    begin
      s1_q <= {FKEY_IN, OPTO_IN};
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_q <= pin_d;
    end
  end

  // ==========================================================
  // axi4-lite slave
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic aw_full_q, w_full_q;
  logic [sli_pkg::ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q, rdata_q, rd_data;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q, rresp_q;
  wire aw_take = AXI_AWVALID_IN & awready_q;
  wire w_take = AXI_WVALID_IN & wready_q;
  wire ar_take = AXI_ARVALID_IN & arready_q;
  wire do_write = aw_full_q & w_full_q & ~bvalid_q;
  wire aw_full_d = (aw_full_q & ~do_write) | aw_take;
  wire w_full_d = (w_full_q & ~do_write) | w_take;
  wire bvalid_d = (bvalid_q & ~AXI_BREADY_IN) | do_write;
  wire rvalid_d = (rvalid_q & ~AXI_RREADY_IN) | ar_take;
  wire [31:0] wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  wire vi_whit = aw_addr_q[11:7] == sli_pkg::OFF_VI_MASK_BASE[11:7];
  wire vi_rhit = AXI_ARADDR_IN[11:7] == sli_pkg::OFF_VI_MASK_BASE[11:7];
  wire [4:0] vi_widx = aw_addr_q[6:2];
  wire [4:0] vi_ridx = AXI_ARADDR_IN[6:2];

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  function automatic logic wr_hit(input logic [11:0] a, input logic [11:0] off);
    wr_hit = a == off;
  endfunction : wr_hit

  wire w_known = vi_whit || (aw_addr_q <= sli_pkg::OFF_VI_MODE && aw_addr_q[1:0] == 2'h0);
  wire r_known = vi_rhit || (AXI_ARADDR_IN <= sli_pkg::OFF_VI_MODE && AXI_ARADDR_IN[1:0] == 2'h0);

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= sli_pkg::RESP_OKAY;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= sli_pkg::RST_WORD;
      w_strb_q <= 4'h0;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= sli_pkg::RST_WORD;
      rresp_q <= sli_pkg::RESP_OKAY;
    end
    else
    begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      awready_q <= ~aw_full_d;
      wready_q <= ~w_full_d;
      if (aw_take)
      begin
        aw_addr_q <= AXI_AWADDR_IN;
      end
      if (w_take)
      begin
        w_data_q <= AXI_WDATA_IN;
        w_strb_q <= AXI_WSTRB_IN;
      end
      bvalid_q <= bvalid_d;
      if (do_write)
      begin
        bresp_q <= w_known ? sli_pkg::RESP_OKAY : sli_pkg::RESP_SLVERR;
      end
      rvalid_q <= rvalid_d;
      arready_q <= ~rvalid_d;
      if (ar_take)
      begin
        rdata_q <= rd_data;
        rresp_q <= r_known ? sli_pkg::RESP_OKAY : sli_pkg::RESP_SLVERR;
      end
    end
  end

  // ==========================================================
  // software registers
  logic [31:0] ctrl_mode_q, vout_q, vi_mode_q;
  logic [31:0] fkey_mode_q, cmd_q, led_drv_q, led_latch_q, cnt_sel_q, cnt_thr_q, vec_sel_q;
  logic [31:0] vi_mask_q [sli_pkg::N_VIO];
  wire wr = do_write;
  wire [sli_pkg::N_CTRL-1:0] ctrl_op = (wr && wr_hit(aw_addr_q, sli_pkg::OFF_CTRL_OP)) ?
                                       (w_data_q & wmask) : '0;
  wire [sli_pkg::N_LED-1:0] led_clr = (wr && wr_hit(aw_addr_q, sli_pkg::OFF_LED_CLR)) ?
                                      w_data_q[sli_pkg::N_LED-1:0] : '0;
  wire cnt_clr = wr && wr_hit(aw_addr_q, sli_pkg::OFF_CNT_CLR) && w_data_q[0];

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      ctrl_mode_q <= sli_pkg::RST_WORD;
      fkey_mode_q <= sli_pkg::RST_WORD;
      cmd_q <= sli_pkg::RST_WORD;
      vout_q <= sli_pkg::RST_WORD;
      led_drv_q <= sli_pkg::RST_WORD;
      led_latch_q <= sli_pkg::RST_WORD;
      cnt_sel_q <= sli_pkg::RST_WORD;
      cnt_thr_q <= sli_pkg::RST_WORD;
      vec_sel_q <= sli_pkg::RST_WORD;
      vi_mode_q <= sli_pkg::RST_WORD;
    end
    else if (wr)
    begin
      case (aw_addr_q)
        sli_pkg::OFF_CTRL_MODE: ctrl_mode_q <= merge(ctrl_mode_q, w_data_q, wmask);
        sli_pkg::OFF_FKEY_MODE: fkey_mode_q <= merge(fkey_mode_q, w_data_q, wmask);
        sli_pkg::OFF_CMD: cmd_q <= merge(cmd_q, w_data_q, wmask);
        sli_pkg::OFF_VOUT: vout_q <= merge(vout_q, w_data_q, wmask);
        sli_pkg::OFF_LED_DRV: led_drv_q <= merge(led_drv_q, w_data_q, wmask);
        sli_pkg::OFF_LED_LATCH: led_latch_q <= merge(led_latch_q, w_data_q, wmask);
        sli_pkg::OFF_CNT_SEL: cnt_sel_q <= merge(cnt_sel_q, w_data_q, wmask);
        sli_pkg::OFF_CNT_THR: cnt_thr_q <= merge(cnt_thr_q, w_data_q, wmask);
        sli_pkg::OFF_VEC_SEL: vec_sel_q <= merge(vec_sel_q, w_data_q, wmask);
        sli_pkg::OFF_VI_MODE: vi_mode_q <= merge(vi_mode_q, w_data_q, wmask);
        default: vout_q <= vout_q;
      endcase
    end
  end

  // ==========================================================
  // virtual inputs: masked bit pairs joined by OR, or AND when mode set
  logic [sli_pkg::N_VIO-1:0] vin;
  genvar gi;
  generate
    for (gi = 0; gi < sli_pkg::N_VIO; gi++)
    begin : g_vin
      wire [31:0] m = vi_mask_q[gi];
      assign vin[gi] = vi_mode_q[gi] ? ((|m) & (&(VI_PAIR_IN | ~m))) : |(VI_PAIR_IN & m);
      always_ff @(posedge CLK_IN or negedge RST_N_IN)
      begin
        if (!RST_N_IN)
        begin
          vi_mask_q[gi] <= sli_pkg::RST_WORD;
        end
        else if (wr && vi_whit && vi_widx == 5'(gi))
        begin
          vi_mask_q[gi] <= merge(vi_mask_q[gi], w_data_q, wmask);
        end
      end
    end
  endgenerate

  // ==========================================================
  // control inputs, function keys, led conditioners
  logic [sli_pkg::N_CTRL-1:0] ctrl_lat_q, ctrl_pend_q, ctrl_pls_q;
  logic [sli_pkg::N_FKEY-1:0] fkey_prev_q, fkey_tog_q;
  logic [sli_pkg::N_LED-1:0] lat_r_q, lat_g_q, led_r_q, led_g_q;
  wire [sli_pkg::N_CTRL-1:0] cmode = ctrl_mode_q;
  wire [sli_pkg::N_CTRL-1:0] ctrl_val = (ctrl_lat_q & cmode) | (ctrl_pls_q & ~cmode);
  wire [sli_pkg::N_FKEY-1:0] fmode = fkey_mode_q[sli_pkg::N_FKEY-1:0];
  wire [sli_pkg::N_FKEY-1:0] fkey_rise = fkey_s & ~fkey_prev_q;
  wire [sli_pkg::N_FKEY-1:0] fkey_val = (fmode & fkey_tog_q) | (~fmode & fkey_s);
  wire [sli_pkg::N_LED-1:0] lmode = led_latch_q[sli_pkg::N_LED-1:0];
  wire [sli_pkg::N_LED-1:0] in_r = led_drv_q[sli_pkg::N_LED-1:0];
  wire [sli_pkg::N_LED-1:0] in_g = led_drv_q[sli_pkg::LED_GRN_LSB +: sli_pkg::N_LED];

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      ctrl_lat_q <= '0;
      ctrl_pend_q <= '0;
      ctrl_pls_q <= '0;
      fkey_prev_q <= '0;
      fkey_tog_q <= '0;
      lat_r_q <= '0;
      lat_g_q <= '0;
      led_r_q <= '0;
      led_g_q <= '0;
    end
    else
    begin
      ctrl_lat_q <= ctrl_lat_q ^ (ctrl_op & cmode);
      ctrl_pend_q <= (ctrl_pend_q & ~{sli_pkg::N_CTRL{scan_tick_q}}) | (ctrl_op & ~cmode);
      if (scan_tick_q)
      begin
        ctrl_pls_q <= ctrl_pend_q;
      end
      fkey_prev_q <= fkey_s;
      fkey_tog_q <= fkey_tog_q ^ fkey_rise;
      lat_r_q <= (lat_r_q & ~led_clr) | (in_r & lmode);
      lat_g_q <= (lat_g_q & ~led_clr) | (in_g & lmode);
      led_r_q <= in_r | (lat_r_q & lmode);
      led_g_q <= in_g | (lat_g_q & lmode);
    end
  end

  // ==========================================================
  // signal vector, rebuilt at every scan tick
  logic [sli_pkg::SIG_W-1:0] vec_q, vec_d;
  logic [sli_pkg::CNT_W-1:0] cnt_count;
  logic cnt_hit;

  always_comb
  begin
    vec_d = '0;
    vec_d[sli_pkg::IDX_CONTACT_BASE +: sli_pkg::N_CONTACT] = CONTACT_IN;
    vec_d[sli_pkg::IDX_OPTO_BASE +: sli_pkg::N_OPTO] = opto_s;
    vec_d[sli_pkg::IDX_RED_LED_BASE +: sli_pkg::N_LED] = led_r_q;
    vec_d[sli_pkg::IDX_EMERG_START] = cmd_q[sli_pkg::CMD_EMERG_BIT];
    vec_d[sli_pkg::IDX_MOTOR_START_OK] = MOTOR_START_OK_IN;
    vec_d[sli_pkg::IDX_FAULT_TRIG] = cmd_q[sli_pkg::CMD_FAULT_BIT];
    vec_d[sli_pkg::IDX_VOUT_BASE +: sli_pkg::N_VIO] = vout_q;
    vec_d[sli_pkg::IDX_VIN_BASE +: sli_pkg::N_VIO] = vin;
    vec_d[sli_pkg::IDX_CTRL_BASE +: sli_pkg::N_CTRL] = ctrl_val;
    vec_d[sli_pkg::IDX_TRI_LED_BASE +: sli_pkg::N_LED] = led_r_q | led_g_q;
    vec_d[sli_pkg::IDX_FKEY_BASE +: sli_pkg::N_FKEY] = fkey_val;
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      vec_q <= '0;
    end
    else if (scan_tick_q)
    begin
      vec_q <= vec_d;
    end
  end

  sli_event_counter u_counter (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .tick_in(scan_tick_q),
    .clr_in(cnt_clr),
    .sig_in(vec_q[cnt_sel_q[sli_pkg::SEL_W-1:0]]),
    .thr_in(cnt_thr_q[sli_pkg::CNT_W-1:0]),
    .count_out(cnt_count),
    .hit_out(cnt_hit)
  );

  // ==========================================================
  // read decode
  wire [4:0] vsel = vec_sel_q[4:0];
  wire [31:0] vec_word = (vsel < 5'(sli_pkg::VEC_WORDS)) ? vec_q[{vsel, 5'h00} +: 32] : '0;
  always_comb
  begin
    case (AXI_ARADDR_IN)
      sli_pkg::OFF_CTRL_MODE: rd_data = ctrl_mode_q;
      sli_pkg::OFF_CTRL_STATE: rd_data = ctrl_val;
      sli_pkg::OFF_FKEY_MODE: rd_data = fkey_mode_q;
      sli_pkg::OFF_FKEY_STATE: rd_data = {22'h000000, fkey_val};
      sli_pkg::OFF_CMD: rd_data = cmd_q;
      sli_pkg::OFF_VOUT: rd_data = vout_q;
      sli_pkg::OFF_LED_DRV: rd_data = led_drv_q;
      sli_pkg::OFF_LED_LATCH: rd_data = led_latch_q;
      sli_pkg::OFF_LED_STATE: rd_data = {16'h0000, led_g_q, led_r_q};
      sli_pkg::OFF_CNT_SEL: rd_data = cnt_sel_q;
      sli_pkg::OFF_CNT_THR: rd_data = cnt_thr_q;
      sli_pkg::OFF_CNT_STATUS: rd_data = {15'h0000, cnt_hit, cnt_count};
      sli_pkg::OFF_VEC_SEL: rd_data = vec_sel_q;
      sli_pkg::OFF_VEC_DATA: rd_data = vec_word;
      sli_pkg::OFF_VI_MODE: rd_data = vi_mode_q;
      default: rd_data = vi_rhit ? vi_mask_q[vi_ridx] : sli_pkg::RST_WORD;
    endcase
  end

  // ==========================================================
  // outputs
  assign EMERG_START_OUT = vec_q[sli_pkg::IDX_EMERG_START];
  assign FAULT_TRIG_OUT = vec_q[sli_pkg::IDX_FAULT_TRIG];
  assign VIRT_OUT_OUT = vec_q[sli_pkg::IDX_VOUT_BASE +: sli_pkg::N_VIO];
  assign LED_RED_OUT = led_r_q;
  assign LED_GRN_OUT = led_g_q;
  assign AXI_AWREADY_OUT = awready_q;
  assign AXI_WREADY_OUT = wready_q;
  assign AXI_BVALID_OUT = bvalid_q;
  assign AXI_BRESP_OUT = bresp_q;
  assign AXI_ARREADY_OUT = arready_q;
  assign AXI_RVALID_OUT = rvalid_q;
  assign AXI_RDATA_OUT = rdata_q;
  assign AXI_RRESP_OUT = rresp_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  localparam int PLS_MAX = 45;

  property p_opto;
    scan_tick_q |=> vec_q[sli_pkg::IDX_OPTO_BASE] == $past(opto_s[0]);
  endproperty
  a_opto: assert property (p_opto) else $error("opto bit not in vector");
  property p_motor;
    scan_tick_q |=> vec_q[sli_pkg::IDX_MOTOR_START_OK] == $past(MOTOR_START_OK_IN);
  endproperty
  a_motor: assert property (p_motor) else $error("motor start bit wrong");
  property p_emerg;
    scan_tick_q && cmd_q[sli_pkg::CMD_EMERG_BIT] |=> EMERG_START_OUT;
  endproperty
  a_emerg: assert property (p_emerg) else $error("emergency start not driven");
  property p_vin_or;
    scan_tick_q && !vi_mode_q[0] && (VI_PAIR_IN & vi_mask_q[0]) != 0
      |=> vec_q[sli_pkg::IDX_VIN_BASE];
  endproperty
  a_vin_or: assert property (p_vin_or) else $error("virtual input not set");
  property p_vout;
    scan_tick_q |=> VIRT_OUT_OUT == $past(vout_q);
  endproperty
  a_vout: assert property (p_vout) else $error("virtual outputs lag");
  property p_ctrl_pls;
    ctrl_op[0] && !cmode[0] |-> ##[1:PLS_MAX] vec_q[sli_pkg::IDX_CTRL_BASE];
  endproperty
  a_ctrl_pls: assert property (p_ctrl_pls) else $error("pulsed control lost");
  property p_fkey_tog;
    fkey_rise[0] && fmode[0] |=> fkey_tog_q[0] != $past(fkey_tog_q[0]);
  endproperty
  a_fkey_tog: assert property (p_fkey_tog) else $error("function key not toggled");
  property p_fault;
    scan_tick_q && cmd_q[sli_pkg::CMD_FAULT_BIT] |=> FAULT_TRIG_OUT;
  endproperty
  a_fault: assert property (p_fault) else $error("fault trigger not driven");
  property p_contact;
    scan_tick_q |=> vec_q[sli_pkg::N_CONTACT-1:0] == $past(CONTACT_IN);
  endproperty
  a_contact: assert property (p_contact) else $error("contact status wrong");
  property p_yellow;
    in_r[6] && in_g[6] |=> LED_RED_OUT[6] && LED_GRN_OUT[6];
  endproperty
  a_yellow: assert property (p_yellow) else $error("yellow not shown");
  property p_latch;
    lmode[6] && led_r_q[6] && !in_r[6] && !led_clr[6] && !$past(led_clr[6]) |=> led_r_q[6];
  endproperty
  a_latch: assert property (p_latch) else $error("latched led dropped");
  property p_scan;
    !scan_tick_q |=> $stable(vec_q);
  endproperty
  a_scan: assert property (p_scan) else $error("vector changed off scan");

  c_yellow: cover property (LED_RED_OUT[6] && LED_GRN_OUT[6]);
  c_ctrl_lat: cover property (ctrl_op[0] && cmode[0]);
  c_vin_and: cover property (vi_mode_q[0] && vec_q[sli_pkg::IDX_VIN_BASE]);
  c_wr: cover property (AXI_BVALID_OUT && AXI_BREADY_IN);

endmodule : sli_signal_if

// file: sli_far_model.sv
// far-side model: protection functions and network bit-pair echo
`timescale 1ns/1ps
module sli_far_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // drives from the block
  input wire logic emerg_in,
  input wire logic [31:0] vout_in,
  // sources into the block
  output logic motor_ok_out,
  output logic [31:0] vi_pair_out
);
  // the motor starts one cycle after the start command; sent pairs loop back
  // each loop link is plain, has one driver and is made once
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in) {motor_ok_out, vi_pair_out} <= 33'h0_0000_0000;
    else {motor_ok_out, vi_pair_out} <= {emerg_in, vout_in};
endmodule : sli_far_model

// file: tb_top.sv
// self-checking bench for the scheme logic signal interface
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("FAIL %s exp %h got %h", n, e, g); end end
module tb_top;
  logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [11:0] awa = 12'h000, ara = 12'h000;
  logic [31:0] wd = 32'h0000_0000, rdat;
  logic [15:0] opto = 16'h0000, cont = 16'h0000;
  logic [9:0] fkey = 10'h000;
  logic [1:0] rsp;
  logic aw_r, w_r, b_v, ar_r, r_v, emerg, fault, mok;
  logic [1:0] bresp, rresp;
  logic [31:0] rd_w, vout, vin;
  logic [7:0] red, grn;
  int fail_count = 0, n_checks = 0;
  sli_signal_if dut (.CLK_IN(clk), .RST_N_IN(rst_n), .OPTO_IN(opto), .FKEY_IN(fkey),
    .CONTACT_IN(cont), .MOTOR_START_OK_IN(mok), .VI_PAIR_IN(vin), .EMERG_START_OUT(emerg),
    .FAULT_TRIG_OUT(fault), .VIRT_OUT_OUT(vout), .LED_RED_OUT(red), .LED_GRN_OUT(grn),
    .AXI_AWADDR_IN(awa), .AXI_AWVALID_IN(awv), .AXI_AWREADY_OUT(aw_r), .AXI_WDATA_IN(wd),
    .AXI_WSTRB_IN(4'hf), .AXI_WVALID_IN(wv), .AXI_WREADY_OUT(w_r), .AXI_BRESP_OUT(bresp),
    .AXI_BVALID_OUT(b_v), .AXI_BREADY_IN(bry), .AXI_ARADDR_IN(ara), .AXI_ARVALID_IN(arv),
    .AXI_ARREADY_OUT(ar_r), .AXI_RDATA_OUT(rd_w), .AXI_RRESP_OUT(rresp),
    .AXI_RVALID_OUT(r_v), .AXI_RREADY_IN(rry));
  sli_far_model far (.clk_in(clk), .rst_n_in(rst_n), .emerg_in(emerg), .vout_in(vout),
    .motor_ok_out(mok), .vi_pair_out(vin));
  always #2.5 clk = ~clk;
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
    do begin @(posedge clk); if (aw_r) awv <= 1'b0; if (w_r) wv <= 1'b0; end
    while (b_v !== 1'b1);
    rsp = bresp; bry <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    ara <= a; arv <= 1'b1; rry <= 1'b1;
    do begin @(posedge clk); if (ar_r) arv <= 1'b0; end while (r_v !== 1'b1);
    rdat = rd_w; rsp = rresp; rry <= 1'b0;
    @(posedge clk);
  endtask : rd
  task automatic scan;
    repeat (40) @(posedge clk);
  endtask : scan
  task automatic vbit(input int i, input logic e);
    wr(sli_pkg::OFF_VEC_SEL, 32'(i / 32));
    rd(sli_pkg::OFF_VEC_DATA);
    `CHK("vector bit", e, rdat[i % 32])
  endtask : vbit
  task automatic t_bus;
    rd(12'h800);
    `CHK("unmapped rresp", sli_pkg::RESP_SLVERR, rsp)
    wr(12'h800, 32'h0000_0001);
    `CHK("unmapped bresp", sli_pkg::RESP_SLVERR, rsp)
  endtask : t_bus
  task automatic t_cmd;
    wr(sli_pkg::OFF_CMD, 32'h0000_0003);
    scan();
    `CHK("emerg", 1'b1, emerg)
    `CHK("fault", 1'b1, fault)
    scan();
    vbit(sli_pkg::IDX_MOTOR_START_OK, 1'b1);
    wr(sli_pkg::OFF_CMD, 32'h0000_0000);
    scan();
    `CHK("emerg off", 1'b0, emerg)
  endtask : t_cmd
  task automatic t_src;
    opto <= 16'h0001; cont <= 16'h0001; fkey <= 10'h001;
    wr(sli_pkg::OFF_VI_MODE, 32'h0000_0001);
    wr(sli_pkg::OFF_VI_MASK_BASE, 32'h0000_0003);
    wr(sli_pkg::OFF_VOUT, 32'h0000_0001);
    scan();
    `CHK("vout", 1'b1, vout[0])
    vbit(sli_pkg::IDX_VIN_BASE, 1'b0);
    vbit(sli_pkg::IDX_CONTACT_BASE, 1'b1);
    vbit(sli_pkg::IDX_OPTO_BASE, 1'b1);
    vbit(sli_pkg::IDX_FKEY_BASE, 1'b1);
    fkey <= 10'h000;
    wr(sli_pkg::OFF_VOUT, 32'h0000_0003);
    scan();
    vbit(sli_pkg::IDX_VIN_BASE, 1'b1);
    vbit(sli_pkg::IDX_FKEY_BASE, 1'b0);
    wr(sli_pkg::OFF_VI_MODE, 32'h0000_0000);
    wr(sli_pkg::OFF_VOUT, 32'h0000_0002);
    scan();
    vbit(sli_pkg::IDX_VIN_BASE, 1'b1);
  endtask : t_src
  task automatic t_cnt;
    wr(sli_pkg::OFF_CNT_SEL, 32'(sli_pkg::IDX_OPTO_BASE));
    wr(sli_pkg::OFF_CNT_THR, 32'h0000_0001);
    wr(sli_pkg::OFF_CNT_CLR, 32'h0000_0001);
    for (int k = 1; k <= 2; k++)
    begin
      opto <= 16'h0000;
      scan();
      scan();
      opto <= 16'h0001;
      scan();
      scan();
      rd(sli_pkg::OFF_CNT_STATUS);
      `CHK("counter", {15'h0000, k > 1, 16'(k)}, rdat)
    end
  endtask : t_cnt
  task automatic t_fkey;
    logic s;
    wr(sli_pkg::OFF_FKEY_MODE, 32'h0000_0001);
    rd(sli_pkg::OFF_FKEY_STATE);
    s = rdat[0];
    repeat (2)
    begin
      fkey <= 10'h001;
      scan();
      fkey <= 10'h000;
      scan();
      s = ~s;
      vbit(sli_pkg::IDX_FKEY_BASE, s);
    end
  endtask : t_fkey
  task automatic t_led;
    wr(sli_pkg::OFF_LED_DRV, 32'h0000_4000);
    scan();
    `CHK("green", 2'b01, {red[6], grn[6]})
    wr(sli_pkg::OFF_LED_DRV, 32'h0000_4040);
    scan();
    `CHK("yellow", 2'b11, {red[6], grn[6]})
    vbit(sli_pkg::IDX_TRI_LED_BASE + 6, 1'b1);
    wr(sli_pkg::OFF_LED_LATCH, 32'h0000_0040);
    wr(sli_pkg::OFF_LED_DRV, 32'h0000_0000);
    scan();
    `CHK("latched", 1'b1, red[6])
    wr(sli_pkg::OFF_LED_CLR, 32'h0000_0040);
    scan();
    `CHK("cleared", 1'b0, red[6])
    wr(sli_pkg::OFF_LED_LATCH, 32'h0000_0000);
    scan();
    `CHK("follow", 1'b0, red[6])
  endtask : t_led
  task automatic t_ctrl;
    logic seen;
    wr(sli_pkg::OFF_CTRL_MODE, 32'h0000_0001);
    wr(sli_pkg::OFF_CTRL_OP, 32'h0000_0001);
    scan();
    vbit(sli_pkg::IDX_CTRL_BASE, 1'b1);
    wr(sli_pkg::OFF_CTRL_OP, 32'h0000_0001);
    scan();
    vbit(sli_pkg::IDX_CTRL_BASE, 1'b0);
    wr(sli_pkg::OFF_CTRL_MODE, 32'h0000_0000);
    wr(sli_pkg::OFF_CTRL_OP, 32'h0000_0001);
    seen = 1'b0;
    repeat (14)
    begin
      rd(sli_pkg::OFF_CTRL_STATE);
      if (rdat[0]) seen = 1'b1;
    end
    `CHK("pulse seen", 1'b1, seen)
    scan();
    rd(sli_pkg::OFF_CTRL_STATE);
    `CHK("pulse end", 1'b0, rdat[0])
  endtask : t_ctrl
  task automatic finish_test;
    if (fail_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_bus(); t_cmd(); t_src(); t_cnt(); t_fkey(); t_led(); t_ctrl();
    finish_test();
  end
  initial begin
    #100us;
    fail_count++;
    finish_test();
  end
endmodule : tb_top
